//--- logic/dcdc_map.vh
`ifndef DCDC_MAP_VH
`define DCDC_MAP_VH
// Register addresses
`define DCDC_ADDR_CONTROL 8'hd1
`define DCDC_ADDR_ADJUST 8'hd2
// Control register fields
`define DCDC_CTL_OFF 7
`define DCDC_CTL_STANDBY 6
`define DCDC_CTL_COEF_SWAP 5
`define DCDC_CTL_MEAS_EN 4
`define DCDC_CTL_STABLE 1
`define DCDC_CTL_BATLOW 0
// Adjust register fields
`define DCDC_ADJ_BG_HI 7
`define DCDC_ADJ_BG_LO 6
`define DCDC_ADJ_SBY_HI 5
`define DCDC_ADJ_SBY_LO 4
`define DCDC_ADJ_WMASK 8'hf0
// Reset values
`define DCDC_CONTROL_RST 4'h0
`define DCDC_ADJUST_RST 4'h0
`define DCDC_COEF_DEFAULT 8'h5a
// Timing
`define DCDC_CLK_HZ 40000000
`define DCDC_MEAS_SETTLE_NS 500000
// Settle time in system clocks: 0.5 ms at 40 MHz, sized to the counter width
`define DCDC_MEAS_CYCLES 16'h4e20
`define DCDC_OFF_SLOW_PERIODS 16'h000f
`define DCDC_CNT_W 16
`endif

//--- logic/dcdc_coef_store.v
`timescale 1ns/1ps
module dcdc_coef_store (
  input wire sys_clk_in,
  input wire por_in,
  input wire wr_en_in,
  input wire [7:0] wr_data_in,
  output reg [7:0] rd_data_out
);
`include "dcdc_map.vh"
  // Only power-on loads the default; system reset and off mode keep contents
  always @(posedge sys_clk_in)
  begin
    if (por_in)
      rd_data_out <= `DCDC_COEF_DEFAULT;
    else if (wr_en_in)
      rd_data_out <= wr_data_in;
  end
endmodule // dcdc_coef_store

//--- logic/dcdc_tick_count.v
`timescale 1ns/1ps
module dcdc_tick_count (
  input wire sys_clk_in,
  input wire clear_in,
  input wire tick_in,
  input wire [15:0] limit_in,
  output reg done_out
);
  reg [15:0] count_reg;
  always @(posedge sys_clk_in)
  begin
    if (clear_in)
    begin
      count_reg <= 16'h0000;
      done_out <= 1'b0;
    end
    else if (tick_in && !done_out)
    begin
      count_reg <= count_reg + 16'h0001;
      done_out <= (count_reg + 16'h0001 >= limit_in);
    end
  end
endmodule // dcdc_tick_count

//--- logic/dcdc_ctrl_regs.v
`timescale 1ns/1ps
// What this block does
// [R01] Control bit 7 forces off mode
// [R02] Control bit 6 selects slow-clock standby
// [R03] Software, not hardware, leaves standby
// [R04] Bit 5 high loads stored coefficients
// [R05] Bit 5 low saves live coefficients
// [R06] Coefficient store survives off, defaults at power-on
// [R07] Bit 4 enables measurement, valid after 0.5 ms
// [R08] Receiver load recommended during measurement
// [R09] Measurement disabled reads battery-low as one
// [R10] Bit 1 shows supply stable status
// [R11] Bit 0 shows battery comparator result
// [R12] Adjust bits 7:6 trim bandgap
// [R13] Adjust bits 5:4 set standby level
// [R14] Off completes after 15 slow periods
// [R15] Stable loss raises interrupt request
// [R16] External reset clears measurement enable
// [R17] Control register at address D1H
// [R18] Unused bits ignore writes, read zero
// [R19] Read-only status bits ignore writes
module dcdc_ctrl_regs (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire por_in,
  input wire [7:0] sfr_addr_in,
  input wire sfr_wr_in,
  input wire sfr_rd_in,
  input wire [7:0] sfr_wdata_in,
  input wire slow_tick_in,
  input wire supply_ok_in,
  input wire comparator_low_in,
  input wire [7:0] live_coef_in,
  output reg [7:0] sfr_rdata_out,
  output reg off_request_out,
  output reg off_complete_out,
  output reg standby_select_out,
  output reg use_slow_clock_out,
  output reg coef_load_out,
  output reg [7:0] coef_load_data_out,
  output reg battery_measure_enable_out,
  output reg [1:0] bandgap_trim_out,
  output reg [1:0] standby_level_out,
  output reg stable_lost_irq_out
);
`include "dcdc_map.vh"

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  reg off_reg;
  reg standby_select_reg;
  reg receiver_coef_swap_reg;
  reg battery_measure_enable_reg;
  reg [3:0] converter_adjust_reg;
  reg supply_stable_flag_reg;
  reg battery_low_flag_reg;
  reg supply_ok_prev_reg;
  reg coef_save_reg;
  wire ctl_wr;
  wire adj_wr;
  wire ctl_rd;
  wire adj_rd;
  wire meas_valid;
  wire off_done;
  wire [7:0] stored_coef;
  wire meas_clear;
  wire off_clear;
  wire [7:0] ctl_rd_word;
  wire [7:0] adj_rd_word;

  assign ctl_wr = sfr_wr_in && (sfr_addr_in == `DCDC_ADDR_CONTROL); // [R17]
  assign adj_wr = sfr_wr_in && (sfr_addr_in == `DCDC_ADDR_ADJUST);
  assign ctl_rd = sfr_rd_in && (sfr_addr_in == `DCDC_ADDR_CONTROL); // [R17]
  assign adj_rd = sfr_rd_in && (sfr_addr_in == `DCDC_ADDR_ADJUST);

  ////////////////////////////////////////////////////////////////////////////
  // Control register writes
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      off_reg <= 1'b0;
    else if (ctl_wr)
      off_reg <= sfr_wdata_in[`DCDC_CTL_OFF]; // [R01]
  end

  // Standby stays until software clears it, even under overload
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      standby_select_reg <= 1'b0;
    else if (ctl_wr)
      standby_select_reg <= sfr_wdata_in[`DCDC_CTL_STANDBY]; // [R02] [R03]
  end

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      receiver_coef_swap_reg <= 1'b0;
    else if (ctl_wr)
      receiver_coef_swap_reg <= sfr_wdata_in[`DCDC_CTL_COEF_SWAP];
  end

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      battery_measure_enable_reg <= 1'b0; // [R16]
    else if (ctl_wr)
      battery_measure_enable_reg <= sfr_wdata_in[`DCDC_CTL_MEAS_EN]; // [R07]
  end

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      converter_adjust_reg <= `DCDC_ADJUST_RST;
    else if (adj_wr)
      converter_adjust_reg <= sfr_wdata_in[7:4]; // [R12] [R13] [R18]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coefficient swap: a write of one loads, a write of zero saves
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      coef_load_out <= 1'b0;
    else
      coef_load_out <= ctl_wr && sfr_wdata_in[`DCDC_CTL_COEF_SWAP]; // [R04]
  end

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      coef_save_reg <= 1'b0;
    else
      coef_save_reg <= ctl_wr && !sfr_wdata_in[`DCDC_CTL_COEF_SWAP]; // [R05]
  end

  // Store is not cleared by system reset so a reset or off keeps the set
  dcdc_coef_store u_coef_store (
    .sys_clk_in(sys_clk_in),
    .por_in(por_in),
    .wr_en_in(coef_save_reg),
    .wr_data_in(live_coef_in),
    .rd_data_out(stored_coef)
  ); // [R06]

  always @(posedge sys_clk_in)
  begin
    coef_load_data_out <= stored_coef; // [R04]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Battery measurement settle timer
  assign meas_clear = sys_rst_in || !battery_measure_enable_reg || (ctl_wr && !sfr_wdata_in[`DCDC_CTL_MEAS_EN]);

  dcdc_tick_count u_meas_timer (
    .sys_clk_in(sys_clk_in),
    .clear_in(meas_clear),
    .tick_in(1'b1),
    .limit_in(`DCDC_MEAS_CYCLES),
    .done_out(meas_valid)
  ); // [R07]

  // The comparator result is only trusted once settled; the last
  // indicator value holds meanwhile
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      battery_low_flag_reg <= 1'b1;
    else if (!battery_measure_enable_reg)
      battery_low_flag_reg <= 1'b1; // [R09]
    else if (meas_valid)
      battery_low_flag_reg <= !comparator_low_in; // [R11]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Off sequence counted in slow clock periods
  assign off_clear = sys_rst_in || !off_reg;

  dcdc_tick_count u_off_timer (
    .sys_clk_in(sys_clk_in),
    .clear_in(off_clear),
    .tick_in(slow_tick_in),
    .limit_in(`DCDC_OFF_SLOW_PERIODS),
    .done_out(off_done)
  ); // [R14]

  ////////////////////////////////////////////////////////////////////////////
  // Supply stable flag and its interrupt
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      supply_stable_flag_reg <= 1'b0;
    else
      supply_stable_flag_reg <= supply_ok_in; // [R10]
  end

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      supply_ok_prev_reg <= 1'b0;
    else
      supply_ok_prev_reg <= supply_stable_flag_reg;
  end

  // No interrupt for the supply drop that off mode causes on purpose
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      stable_lost_irq_out <= 1'b0;
    else
      stable_lost_irq_out <= supply_ok_prev_reg && !supply_stable_flag_reg && !off_reg; // [R15]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs toward the converter
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      off_request_out <= 1'b0;
    else
      off_request_out <= off_reg; // [R01]
  end

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      off_complete_out <= 1'b0;
    else
      off_complete_out <= off_done; // [R14]
  end

  // Off overrides the standby select and measurement enable bits
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      standby_select_out <= 1'b0;
    else
      standby_select_out <= standby_select_reg && !off_reg; // [R01] [R02]
  end

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      use_slow_clock_out <= 1'b0;
    else
      use_slow_clock_out <= standby_select_reg || off_reg; // [R02]
  end

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      battery_measure_enable_out <= 1'b0;
    else
      battery_measure_enable_out <= battery_measure_enable_reg && !off_reg; // [R07]
  end

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      bandgap_trim_out <= 2'h0;
    else
      bandgap_trim_out <= converter_adjust_reg[3:2]; // [R12]
  end

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      standby_level_out <= 2'h0;
    else
      standby_level_out <= converter_adjust_reg[1:0]; // [R13]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered; unused bits are zero
  assign ctl_rd_word = {off_reg, standby_select_reg, receiver_coef_swap_reg, battery_measure_enable_reg,
                        2'b00, supply_stable_flag_reg, battery_low_flag_reg}; // [R18] [R19]
  assign adj_rd_word = {converter_adjust_reg, 4'h0}; // [R18]

  // Idle reads return zero so a stray sample never shows stale status
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      sfr_rdata_out <= 8'h00;
    else
    begin
      case ({ctl_rd, adj_rd})
        2'b10:
          sfr_rdata_out <= ctl_rd_word;
        2'b01:
          sfr_rdata_out <= adj_rd_word;
        default:
          sfr_rdata_out <= 8'h00;
      endcase
    end
  end
endmodule // dcdc_ctrl_regs

//--- tb/dcdc_ctrl_regs_asserts.sv
`timescale 1ns/1ps
module dcdc_ctrl_regs_asserts (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire [7:0] sfr_addr_in,
  input wire sfr_wr_in,
  input wire [7:0] sfr_wdata_in,
  input wire slow_tick_in,
  input wire supply_ok_in,
  input wire off_request_out,
  input wire off_complete_out,
  input wire standby_select_out,
  input wire use_slow_clock_out,
  input wire coef_load_out,
  input wire battery_measure_enable_out,
  input wire [1:0] bandgap_trim_out,
  input wire [1:0] standby_level_out,
  input wire stable_lost_irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  reg [4:0] ticks_reg;
  // Saturates so a long off stay cannot wrap
  always @(posedge sys_clk_in)
    ticks_reg <= !off_request_out ? 5'h00 : ticks_reg + {4'h0, slow_tick_in & ~&ticks_reg};
  sequence ctl_wr; sfr_wr_in && sfr_addr_in == 8'hd1; endsequence
  sequence adj_wr; sfr_wr_in && sfr_addr_in == 8'hd2; endsequence
  chk_off_enter: assert property ((ctl_wr ##0 sfr_wdata_in[7]) |-> ##[2:3] off_request_out)
    else $error("off not requested");
  chk_standby_sel: assert property ((ctl_wr ##0 sfr_wdata_in[7:6] == 2'b01) |-> ##[2:3] use_slow_clock_out)
    else $error("standby not selected");
  chk_coef_load: assert property ((ctl_wr ##0 sfr_wdata_in[5]) |-> ##[1:3] coef_load_out)
    else $error("coefficient load missing");
  chk_meas_enable: assert property ((ctl_wr ##0 sfr_wdata_in[4]) |-> ##[2:3] battery_measure_enable_out)
    else $error("measurement not enabled");
  chk_meas_reset: assert property (disable iff (1'b0) sys_rst_in |=> !battery_measure_enable_out)
    else $error("measurement enable kept through reset");
  chk_bandgap_trim: assert property (adj_wr |-> ##3 bandgap_trim_out == $past(sfr_wdata_in[7:6], 3))
    else $error("bandgap trim wrong");
  chk_standby_lvl: assert property (adj_wr |-> ##3 standby_level_out == $past(sfr_wdata_in[5:4], 3))
    else $error("standby level wrong");
  chk_irq_raise: assert property ($fell(supply_ok_in) && !off_request_out |-> ##[1:2] stable_lost_irq_out)
    else $error("stable loss not signalled");
  chk_irq_pulse: assert property (stable_lost_irq_out |=> !stable_lost_irq_out)
    else $error("interrupt pulse too long");
  chk_off_early: assert property (off_complete_out |-> ticks_reg >= 5'h0e)
    else $error("off completed early");
  chk_off_late: assert property (off_request_out && ticks_reg >= 5'h10 |-> off_complete_out)
    else $error("off completed late");
endmodule // dcdc_ctrl_regs_asserts
bind dcdc_ctrl_regs dcdc_ctrl_regs_asserts i_dcdc_ctrl_regs_asserts (.*);

//--- tb/test_dcdc_ctrl_regs.sv
`timescale 1ns/1ps
module test_dcdc_ctrl_regs;
  reg sys_clk_in = 0, sys_rst_in = 1, por_in = 1, sfr_wr_in = 0, sfr_rd_in = 0, slow_tick_in = 0;
  reg supply_ok_in = 1, comparator_low_in = 0;
  reg [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, live_coef_in = 8'h00, r;
  wire [7:0] sfr_rdata_out, coef_load_data_out;
  wire [1:0] bandgap_trim_out, standby_level_out;
  wire off_request_out, off_complete_out, standby_select_out, use_slow_clock_out, coef_load_out;
  wire battery_measure_enable_out, stable_lost_irq_out;
  int error_cnt = 0, checked = 0, cyc = 0;
  logic [7:0] exp_q[$];
  logic rd_d = 0;
  dcdc_ctrl_regs i_dcdc_ctrl_regs (.*);
  ////////////////////////////////////////////////////////////////
  initial forever #12.5 sys_clk_in = ~sys_clk_in;
  // Slow tick far faster than real so off completes quickly
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    slow_tick_in <= #2 (cyc % 8 == 7);
    if (cyc == 30000)
    begin
      error_cnt++;
      end_sim;
    end
  end
  always @(posedge sys_clk_in)
  begin
    if (rd_d)
      check(sfr_rdata_out, exp_q.pop_front(), "read data");
    rd_d <= sfr_rd_in;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input [7:0] seen, input [7:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input w, input [7:0] a, input [7:0] d);
    @(posedge sys_clk_in);
    #2;
    {sfr_wr_in, sfr_rd_in, sfr_addr_in, sfr_wdata_in} = {w, !w, a, d};
    @(posedge sys_clk_in);
    #2;
    {sfr_wr_in, sfr_rd_in} = 2'b00;
    repeat (4) @(posedge sys_clk_in);
    #2;
  endtask
  task automatic rd(input [7:0] a, input [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(2));
    repeat (10) @(posedge sys_clk_in);
    #2;
    sys_rst_in = 0;
    por_in = 0;
    rd(8'hd1, 8'h03);
    rd(8'hd2, 8'h00);
    rd(8'hd0, 8'h00);
    $display("test reset done");
    repeat (4)
    begin
      r = $urandom;
      acc(1'b1, 8'hd2, r);
      rd(8'hd2, r & 8'hf0);
    end
    $display("test adjust done");
    acc(1'b1, 8'hd1, 8'h20);
    check(coef_load_data_out, 8'h5a, "coef default");
    r = $urandom;
    live_coef_in = r;
    acc(1'b1, 8'hd1, 8'h00);
    live_coef_in = ~r;
    acc(1'b1, 8'hd1, 8'h20);
    check(coef_load_data_out, r, "coef saved");
    $display("test coef done");
    acc(1'b1, 8'hd1, 8'h4f);
    check({7'h00, standby_select_out}, 8'h01, "standby select");
    rd(8'hd1, 8'h43);
    $display("test control done");
    acc(1'b1, 8'hd1, 8'h10);
    rd(8'hd1, 8'h13);
    comparator_low_in = 1;
    repeat (20000) @(posedge sys_clk_in);
    rd(8'hd1, 8'h12);
    sys_rst_in = 1;
    @(posedge sys_clk_in);
    #2;
    sys_rst_in = 0;
    rd(8'hd1, 8'h03);
    check(coef_load_data_out, ~r, "coef kept");
    $display("test measure done");
    supply_ok_in = 0;
    rd(8'hd1, 8'h01);
    supply_ok_in = 1;
    $display("test stable done");
    acc(1'b1, 8'hd1, 8'hc0);
    repeat (80) @(posedge sys_clk_in);
    #2;
    check({7'h00, off_complete_out}, 8'h00, "off early");
    check({6'h00, standby_select_out, use_slow_clock_out}, 8'h01, "off overrides standby");
    repeat (60) @(posedge sys_clk_in);
    #2;
    check({7'h00, off_complete_out}, 8'h01, "off done");
    acc(1'b1, 8'hd1, 8'h00);
    $display("test off done");
    end_sim;
  end
endmodule // test_dcdc_ctrl_regs
